// ### hdl/stream_rate_and_ber_rx_regs.sv
// Register bank for per-stream bit rates and backplane error test receive side
// How it works
// R01 - Five-bit stream field picks the backplane input stream checked for errors.
// R02 - Nine-bit channel field gives the first backplane channel compared.
// R03 - Software writes zeros to unused upper bits; they are not stored.
// R04 - Sixteen-bit error count is read only; writes leave it unchanged.
// R05 - Count sticks at all ones until the count-clear bit is written.
// R06 - Local input rate per stream from bits 1:0: 2, 4, 8, 16 Mbps.
// R07 - Local fast mode: local inputs 0-15 at 32 Mbps, 16-31 unused.
// R08 - Local output rate per stream from bits 1:0, same encoding.
// R09 - Local fast mode: local outputs 0-15 at 32 Mbps, 16-31 unused.
// R10 - Backplane input rate per stream from bits 1:0, same encoding.
// R11 - Backplane fast mode: backplane inputs 0-15 at 32 Mbps, rest unused.
// R12 - Backplane output rate per stream from bits 1:0, same encoding.
// R13 - Backplane fast mode: backplane outputs 0-15 at 32 Mbps, rest unused.
// R14 - Compared channels per frame equal receive length value plus one.
// R15 - After reset all rates, start fields and the count read zero.
`timescale 1ns/1ps
`default_nettype none

module stream_rate_and_ber_rx_regs (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [15:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after read strobe
  input wire logic rx_bit_valid, // Received backplane bit present
  input wire logic [4:0] rx_stream, // Stream of the received bit
  input wire logic [8:0] rx_channel, // Channel of the received bit
  input wire logic rx_bit, // Received test pattern bit
  input wire logic ref_bit, // Expected test pattern bit
  output logic err_pulse, // One cycle per detected error, also while the count sticks at all ones
  output logic [95:0] local_in_code, // 3-bit rate code per stream
  output logic [31:0] local_in_en, // Stream in use
  output logic [95:0] local_out_code, // 3-bit rate code per stream
  output logic [31:0] local_out_en, // Stream in use
  output logic [95:0] bp_in_code, // 3-bit rate code per stream
  output logic [31:0] bp_in_en, // Stream in use
  output logic [95:0] bp_out_code, // 3-bit rate code per stream
  output logic [31:0] bp_out_en, // Stream in use
  output logic irq // Level interrupt
);

  typedef logic [stream_rate_pkg::STREAMS-1:0][stream_rate_pkg::RATE_W-1:0] rate_arr_t;
  typedef logic [stream_rate_pkg::STREAMS-1:0][stream_rate_pkg::CODE_W-1:0] code_arr_t;

  typedef struct packed {
    logic [stream_rate_pkg::START_W-1:0] rx_start;
    logic [stream_rate_pkg::CHAN_W-1:0] rx_length;
    logic [stream_rate_pkg::DATA_W-1:0] err_count;
    logic local_fast_mode;
    logic backplane_fast_mode;
    rate_arr_t local_in_rate;
    rate_arr_t local_out_rate;
    rate_arr_t bp_in_rate;
    rate_arr_t bp_out_rate;
    logic [stream_rate_pkg::IRQ_W-1:0] irq_status;
    logic [stream_rate_pkg::IRQ_W-1:0] irq_mask;
    logic [stream_rate_pkg::DATA_W-1:0] rdata;
    logic err_pulse;
    logic irq;
    code_arr_t li_code;
    code_arr_t lo_code;
    code_arr_t bi_code;
    code_arr_t bo_code;
    logic [stream_rate_pkg::STREAMS-1:0] li_en;
    logic [stream_rate_pkg::STREAMS-1:0] lo_en;
    logic [stream_rate_pkg::STREAMS-1:0] bi_en;
    logic [stream_rate_pkg::STREAMS-1:0] bo_en;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // Address falls inside one 32-entry rate array
  function automatic logic array_hit(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] diff;
    diff = addr - base;
    array_hit = (addr >= base) && (diff < 16'(stream_rate_pkg::STREAMS));
  endfunction

  function automatic logic [4:0] array_idx(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] diff;
    diff = addr - base;
    array_idx = diff[4:0];
  endfunction

  // Effective rate code of one stream; fast mode overrides the field
  function automatic logic [2:0] eff_code(input logic [1:0] field, input logic fast,
                                          input int idx);
    if (fast) begin
      eff_code = (idx < stream_rate_pkg::FAST_STREAMS) ? stream_rate_pkg::CODE_FAST :
                 stream_rate_pkg::CODE_NONE;
    end else begin
      eff_code = {1'b0, field};
    end
  endfunction

  // Stream in use; upper half idles in fast mode
  function automatic logic eff_en(input logic fast, input int idx);
    eff_en = !fast || (idx < stream_rate_pkg::FAST_STREAMS);
  endfunction

  // Zero-extended 2-bit rate field as register data
  function automatic logic [15:0] rate_word(input logic [1:0] field);
    rate_word = {14'h0000, field};
  endfunction

  logic [4:0] sel_stream;
  logic [8:0] start_chan;
  logic [9:0] chan_ofs;
  logic in_window;
  logic err_event;
  logic sat_event;
  logic count_clear;
  logic [15:0] rd_word;
  logic [4:0] widx;
  logic [4:0] ridx;

  always_comb begin
    state_nxt = state_r;
    sel_stream = state_r.rx_start[stream_rate_pkg::RX_STREAM_MSB:stream_rate_pkg::RX_STREAM_LSB]; // R01
    start_chan = state_r.rx_start[stream_rate_pkg::RX_CHAN_MSB:stream_rate_pkg::RX_CHAN_LSB]; // R02
    chan_ofs = {1'b0, rx_channel} - {1'b0, start_chan};
    // Window does not wrap past the last channel of the frame
    in_window = (rx_channel >= start_chan) && (chan_ofs <= {1'b0, state_r.rx_length}); // R14
    err_event = rx_bit_valid && (rx_stream == sel_stream) && in_window
                && (rx_bit != ref_bit); // R01 R02
    count_clear = reg_wr && (reg_addr == stream_rate_pkg::ERR_TEST_CONTROL_OFS)
                  && reg_wdata[stream_rate_pkg::COUNT_CLEAR_BIT];
    sat_event = 1'b0;
    widx = array_idx(reg_addr, stream_rate_pkg::LOCAL_IN_RATE_OFS);
    ridx = 5'h00;
    rd_word = stream_rate_pkg::DATA_ZERO;

    // Error count: clear restarts it, but an error in the same cycle still counts
    if (count_clear) begin
      state_nxt.err_count = err_event ? stream_rate_pkg::COUNT_ONE :
                            stream_rate_pkg::DATA_ZERO; // R05
    end else if (err_event && (state_r.err_count != stream_rate_pkg::COUNT_MAX)) begin
      state_nxt.err_count = state_r.err_count + stream_rate_pkg::COUNT_ONE; // R04
      sat_event = (state_r.err_count == stream_rate_pkg::COUNT_MAX - stream_rate_pkg::COUNT_ONE);
    end

    // Register writes; reserved upper bits are dropped
    if (reg_wr) begin
      if (reg_addr == stream_rate_pkg::ERR_RX_START_OFS) begin
        state_nxt.rx_start = reg_wdata[stream_rate_pkg::START_W-1:0]; // R03
      end else if (reg_addr == stream_rate_pkg::ERR_RX_LENGTH_OFS) begin
        state_nxt.rx_length = reg_wdata[stream_rate_pkg::CHAN_W-1:0];
      end else if (reg_addr == stream_rate_pkg::MODE_CTRL_OFS) begin
        state_nxt.local_fast_mode = reg_wdata[stream_rate_pkg::LOCAL_FAST_BIT];
        state_nxt.backplane_fast_mode = reg_wdata[stream_rate_pkg::BP_FAST_BIT];
      end else if (reg_addr == stream_rate_pkg::IRQ_MASK_OFS) begin
        state_nxt.irq_mask = reg_wdata[stream_rate_pkg::IRQ_W-1:0];
      end else if (array_hit(reg_addr, stream_rate_pkg::LOCAL_IN_RATE_OFS)) begin
        state_nxt.local_in_rate[widx] = reg_wdata[stream_rate_pkg::RATE_W-1:0]; // R06 R03
      end else if (array_hit(reg_addr, stream_rate_pkg::LOCAL_OUT_RATE_OFS)) begin
        widx = array_idx(reg_addr, stream_rate_pkg::LOCAL_OUT_RATE_OFS);
        state_nxt.local_out_rate[widx] = reg_wdata[stream_rate_pkg::RATE_W-1:0]; // R08
      end else if (array_hit(reg_addr, stream_rate_pkg::BP_IN_RATE_OFS)) begin
        widx = array_idx(reg_addr, stream_rate_pkg::BP_IN_RATE_OFS);
        state_nxt.bp_in_rate[widx] = reg_wdata[stream_rate_pkg::RATE_W-1:0]; // R10
      end else if (array_hit(reg_addr, stream_rate_pkg::BP_OUT_RATE_OFS)) begin
        widx = array_idx(reg_addr, stream_rate_pkg::BP_OUT_RATE_OFS);
        state_nxt.bp_out_rate[widx] = reg_wdata[stream_rate_pkg::RATE_W-1:0]; // R12
      end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    if (reg_wr && (reg_addr == stream_rate_pkg::IRQ_STATUS_OFS)) begin
      state_nxt.irq_status = state_r.irq_status & ~reg_wdata[stream_rate_pkg::IRQ_W-1:0];
    end
    if (err_event) begin
      state_nxt.irq_status[stream_rate_pkg::IRQ_ERR_BIT] = 1'b1;
    end
    if (sat_event) begin
      state_nxt.irq_status[stream_rate_pkg::IRQ_SAT_BIT] = 1'b1;
    end
    state_nxt.irq = |(state_nxt.irq_status & state_r.irq_mask);
    state_nxt.err_pulse = err_event;

    // Read decode; the count write address has no effect on the count
    if (reg_addr == stream_rate_pkg::ERR_RX_START_OFS) begin
      rd_word = {2'b00, state_r.rx_start};
    end else if (reg_addr == stream_rate_pkg::ERR_COUNT_OFS) begin
      rd_word = state_r.err_count; // R04
    end else if (reg_addr == stream_rate_pkg::ERR_RX_LENGTH_OFS) begin
      rd_word = {7'h00, state_r.rx_length};
    end else if (reg_addr == stream_rate_pkg::MODE_CTRL_OFS) begin
      rd_word = {14'h0000, state_r.backplane_fast_mode, state_r.local_fast_mode};
    end else if (reg_addr == stream_rate_pkg::IRQ_STATUS_OFS) begin
      rd_word = {14'h0000, state_r.irq_status};
    end else if (reg_addr == stream_rate_pkg::IRQ_MASK_OFS) begin
      rd_word = {14'h0000, state_r.irq_mask};
    end else if (array_hit(reg_addr, stream_rate_pkg::LOCAL_IN_RATE_OFS)) begin
      ridx = array_idx(reg_addr, stream_rate_pkg::LOCAL_IN_RATE_OFS);
      rd_word = rate_word(state_r.local_in_rate[ridx]);
    end else if (array_hit(reg_addr, stream_rate_pkg::LOCAL_OUT_RATE_OFS)) begin
      ridx = array_idx(reg_addr, stream_rate_pkg::LOCAL_OUT_RATE_OFS);
      rd_word = rate_word(state_r.local_out_rate[ridx]);
    end else if (array_hit(reg_addr, stream_rate_pkg::BP_IN_RATE_OFS)) begin
      ridx = array_idx(reg_addr, stream_rate_pkg::BP_IN_RATE_OFS);
      rd_word = rate_word(state_r.bp_in_rate[ridx]);
    end else if (array_hit(reg_addr, stream_rate_pkg::BP_OUT_RATE_OFS)) begin
      ridx = array_idx(reg_addr, stream_rate_pkg::BP_OUT_RATE_OFS);
      rd_word = rate_word(state_r.bp_out_rate[ridx]);
    end
    // Read data only in the cycle after the strobe
    state_nxt.rdata = reg_rd ? rd_word : stream_rate_pkg::DATA_ZERO;

    // Effective per-stream rates, from the current registers
    for (int i = 0; i < stream_rate_pkg::STREAMS; i++) begin
      state_nxt.li_code[i] = eff_code(state_r.local_in_rate[i], state_r.local_fast_mode, i); // R06 R07
      state_nxt.li_en[i] = eff_en(state_r.local_fast_mode, i); // R07
      state_nxt.lo_code[i] = eff_code(state_r.local_out_rate[i], state_r.local_fast_mode, i); // R08 R09
      state_nxt.lo_en[i] = eff_en(state_r.local_fast_mode, i); // R09
      state_nxt.bi_code[i] = eff_code(state_r.bp_in_rate[i], state_r.backplane_fast_mode, i); // R10 R11
      state_nxt.bi_en[i] = eff_en(state_r.backplane_fast_mode, i); // R11
      state_nxt.bo_code[i] = eff_code(state_r.bp_out_rate[i], state_r.backplane_fast_mode, i); // R12 R13
      state_nxt.bo_en[i] = eff_en(state_r.backplane_fast_mode, i); // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= '0; // R15
      state_r.li_en <= '1;
      state_r.lo_en <= '1;
      state_r.bi_en <= '1;
      state_r.bo_en <= '1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign err_pulse = state_r.err_pulse;
  assign irq = state_r.irq;
  assign local_in_code = state_r.li_code;
  assign local_in_en = state_r.li_en;
  assign local_out_code = state_r.lo_code;
  assign local_out_en = state_r.lo_en;
  assign bp_in_code = state_r.bi_code;
  assign bp_in_en = state_r.bi_en;
  assign bp_out_code = state_r.bo_code;
  assign bp_out_en = state_r.bo_en;

endmodule

`default_nettype wire

// ### hdl/stream_rate_pkg.sv
// Constants shared by the stream rate and error test register bank
`default_nettype none
package stream_rate_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int STREAMS = 32;
  localparam int FAST_STREAMS = 16;
  localparam int RATE_W = 2;
  localparam int CODE_W = 3;
  localparam int STREAM_W = 5;
  localparam int CHAN_W = 9;
  localparam int START_W = STREAM_W + CHAN_W;
  localparam int IRQ_W = 2;

  // Register offsets; each rate array takes 32 addresses from its base
  localparam logic [ADDR_W-1:0] ERR_RX_START_OFS = 16'h00cb;
  localparam logic [ADDR_W-1:0] ERR_COUNT_OFS = 16'h00cc;
  localparam logic [ADDR_W-1:0] LOCAL_IN_RATE_OFS = 16'h00cd;
  localparam logic [ADDR_W-1:0] LOCAL_OUT_RATE_OFS = 16'h00ed;
  localparam logic [ADDR_W-1:0] BP_IN_RATE_OFS = 16'h010d;
  localparam logic [ADDR_W-1:0] BP_OUT_RATE_OFS = 16'h012d;
  localparam logic [ADDR_W-1:0] MODE_CTRL_OFS = 16'h0160;
  localparam logic [ADDR_W-1:0] ERR_TEST_CONTROL_OFS = 16'h0161;
  localparam logic [ADDR_W-1:0] ERR_RX_LENGTH_OFS = 16'h0162;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 16'h0163;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 16'h0164;

  // Field positions
  localparam int RX_STREAM_MSB = 13;
  localparam int RX_STREAM_LSB = 9;
  localparam int RX_CHAN_MSB = 8;
  localparam int RX_CHAN_LSB = 0;
  localparam int LOCAL_FAST_BIT = 0;
  localparam int BP_FAST_BIT = 1;
  localparam int COUNT_CLEAR_BIT = 0;
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_SAT_BIT = 1;

  // Values
  localparam logic [DATA_W-1:0] COUNT_MAX = 16'hffff;
  localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CODE_W-1:0] CODE_FAST = 3'h4;
  localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
endpackage
`default_nettype wire

// ### sim/host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk, // Clock
  output logic [15:0] reg_addr, // Address
  output logic [15:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata // Read data
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### sim/stream_rate_and_ber_rx_regs_test.sv
// Self-checking bench for the stream rate and error test register bank
`timescale 1ns/1ps
`default_nettype none
module stream_rate_and_ber_rx_regs_test;
  logic core_clk, rst, reg_wr, reg_rd, rx_bit_valid, rx_bit, ref_bit, err_pulse, irq;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [4:0] rx_stream;
  logic [8:0] rx_channel;
  logic [95:0] local_in_code, local_out_code, bp_in_code, bp_out_code, v;
  logic [31:0] local_in_en, local_out_en, bp_in_en, bp_out_en;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  localparam logic [15:0] BASE [4] = '{stream_rate_pkg::LOCAL_IN_RATE_OFS,
    stream_rate_pkg::LOCAL_OUT_RATE_OFS, stream_rate_pkg::BP_IN_RATE_OFS,
    stream_rate_pkg::BP_OUT_RATE_OFS};
  localparam int SEL [4] = '{0, 31, 5, 16};
  host_model host_model_i (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  stream_rate_and_ber_rx_regs stream_rate_and_ber_rx_regs_i (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_bit_valid, .rx_stream, .rx_channel, .rx_bit,
    .ref_bit, .err_pulse, .local_in_code, .local_in_en, .local_out_code, .local_out_en,
    .bp_in_code, .bp_in_en, .bp_out_code, .bp_out_en, .irq);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic bit_in(input logic [4:0] s, input logic [8:0] c, input logic r, f, e);
    @(posedge core_clk);
    rx_stream <= s;
    rx_channel <= c;
    rx_bit <= r;
    ref_bit <= f;
    rx_bit_valid <= 1'b1;
    @(posedge core_clk);
    rx_bit_valid <= 1'b0;
    #1 chk(err_pulse, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  initial begin
    rst = 1'b1;
    rx_bit_valid = 1'b0;
    rx_stream = 5'h00;
    rx_channel = 9'h000;
    rx_bit = 1'b0;
    ref_bit = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    chk(local_in_code | local_out_code | bp_in_code | bp_out_code, 96'h0);
    host_model_i.rd(stream_rate_pkg::ERR_RX_START_OFS, d);
    chk(d, 16'h0000);
    for (int a = 0; a < 4; a++) begin
      for (int c = 0; c < 4; c++) begin
        host_model_i.wr(BASE[a] + 16'(SEL[a]), 16'(c));
        settle();
        v = a == 0 ? local_in_code : a == 1 ? local_out_code : a == 2 ? bp_in_code : bp_out_code;
        chk(v[3*SEL[a] +: 3], 3'(c));
        host_model_i.rd(BASE[a] + 16'(SEL[a]), d);
        chk(d, 16'(c));
      end
    end
    host_model_i.wr(stream_rate_pkg::MODE_CTRL_OFS, 16'h0003);
    settle();
    chk(local_in_en & bp_out_en, 32'h0000ffff);
    chk(local_out_en & bp_in_en, 32'h0000ffff);
    chk({local_out_code[95:48], bp_in_code[95:48]}, 96'h0);
    chk({local_out_code[2:0], bp_in_code[47:45]}, 6'h24);
    host_model_i.wr(stream_rate_pkg::MODE_CTRL_OFS, 16'h0000);
    settle();
    chk(bp_in_code[17:15], 3'h3);
    host_model_i.wr(stream_rate_pkg::ERR_RX_START_OFS, 16'h3fff);
    host_model_i.rd(stream_rate_pkg::ERR_RX_START_OFS, d);
    chk(d, 16'h3fff);
    host_model_i.wr(stream_rate_pkg::ERR_RX_START_OFS, 16'h060a);
    host_model_i.wr(stream_rate_pkg::ERR_RX_LENGTH_OFS, 16'h0001);
    host_model_i.wr(stream_rate_pkg::IRQ_MASK_OFS, 16'h0001);
    bit_in(5'h03, 9'h00a, 1'b1, 1'b0, 1'b1);
    bit_in(5'h03, 9'h00b, 1'b0, 1'b1, 1'b1);
    bit_in(5'h03, 9'h00c, 1'b1, 1'b0, 1'b0);
    bit_in(5'h03, 9'h009, 1'b1, 1'b0, 1'b0);
    bit_in(5'h04, 9'h00a, 1'b1, 1'b0, 1'b0);
    bit_in(5'h03, 9'h00a, 1'b1, 1'b1, 1'b0);
    chk(irq, 1'b1);
    host_model_i.wr(stream_rate_pkg::ERR_COUNT_OFS, 16'h1234);
    host_model_i.rd(stream_rate_pkg::ERR_COUNT_OFS, d);
    chk(d, 16'h0002);
    host_model_i.wr(stream_rate_pkg::IRQ_STATUS_OFS, 16'h0003);
    settle();
    chk(irq, 1'b0);
    host_model_i.rd(16'h0000, d);
    chk(d, 16'h0000);
    host_model_i.wr(stream_rate_pkg::IRQ_MASK_OFS, 16'h0000);
    bit_in(5'h03, 9'h00a, 1'b1, 1'b0, 1'b1);
    settle();
    chk(irq, 1'b0);
    // Long mismatch burst drives the count past its top
    @(posedge core_clk);
    rx_bit_valid <= 1'b1;
    repeat (65540) @(posedge core_clk);
    rx_bit_valid <= 1'b0;
    host_model_i.rd(stream_rate_pkg::ERR_COUNT_OFS, d);
    chk(d, 16'hffff);
    host_model_i.rd(stream_rate_pkg::IRQ_STATUS_OFS, d);
    chk(d, 16'h0003);
    host_model_i.wr(stream_rate_pkg::ERR_TEST_CONTROL_OFS, 16'h0001);
    host_model_i.rd(stream_rate_pkg::ERR_COUNT_OFS, d);
    chk(d, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire

// ### sim/stream_rate_checker_assertions.sv
// Port assertions for the stream rate and error test register bank
`timescale 1ns/1ps
`default_nettype none
module stream_rate_checker (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [15:0] reg_addr, // Address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic rx_bit_valid, // Bit present
  input wire logic rx_bit, // Received bit
  input wire logic ref_bit, // Expected bit
  input wire logic err_pulse, // Error pulse
  input wire logic [95:0] local_in_code, // Codes
  input wire logic [31:0] local_in_en, // Enables
  input wire logic [95:0] local_out_code, // Codes
  input wire logic [95:0] bp_out_code, // Codes
  input wire logic [31:0] bp_out_en // Enables
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  err_cause_a: assert property (err_pulse |-> $past(rx_bit_valid && rx_bit != ref_bit))
    else $error("error pulse without a mismatching bit");
  lin_fast_a: assert property (local_in_en[31:16] == 16'h0000 |->
    local_in_code[95:48] == 48'h0 && local_in_code[2:0] == 3'h4)
    else $error("local fast mode codes wrong");
  bout_fast_a: assert property (bp_out_en[31:16] == 16'h0000 |->
    bp_out_code[95:48] == 48'h0 && bp_out_code[47:45] == 3'h4)
    else $error("backplane fast mode codes wrong");
  lin_slow_a: assert property (local_in_en[31] |-> local_in_code[2] == 1'b0)
    else $error("fast code outside fast mode");
  // Guarded by the enable so a mode change in between does not fire it
  lin_wr_a: assert property (reg_wr && reg_addr == stream_rate_pkg::LOCAL_IN_RATE_OFS ##2
    local_in_en[31] |-> local_in_code[2:0] == {1'b0, $past(reg_wdata[1:0], 2)})
    else $error("local input rate not applied");
  lout_wr_a: assert property (reg_wr && reg_addr == stream_rate_pkg::LOCAL_OUT_RATE_OFS + 16'h1f
    ##2 local_in_en[31] |-> local_out_code[95:93] == {1'b0, $past(reg_wdata[1:0], 2)})
    else $error("local output rate not applied");
  bout_wr_a: assert property (reg_wr && reg_addr == stream_rate_pkg::BP_OUT_RATE_OFS + 16'h10
    ##2 bp_out_en[31] |-> bp_out_code[50:48] == {1'b0, $past(reg_wdata[1:0], 2)})
    else $error("backplane output rate not applied");
endmodule
bind stream_rate_and_ber_rx_regs stream_rate_checker stream_rate_checker_i (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_bit_valid, .rx_bit, .ref_bit,
  .err_pulse, .local_in_code, .local_in_en, .local_out_code, .bp_out_code, .bp_out_en);
`default_nettype wire
